// *** pkg/dlc_pkg.sv ***
// Purpose: Shared constants and types for the DC-balance link encoder.
// Assumes: Seven-bit serial words per line and per pixel clock.
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus.
`default_nettype none
package dlc_pkg;

  // Serial word layout: one balance bit above six pixel bits.
  localparam int unsigned WORD_W = 7;
  localparam int unsigned DATA_W = 6;
  localparam int unsigned BALANCE_POS = 6;

  // Running disparity limits and its value after reset.
  localparam logic signed [5:0] RD_MAX = 6'sh07;
  localparam logic signed [5:0] RD_MIN = -6'sh06;
  localparam logic signed [3:0] RD_RESET = 4'sh0;

  // Blanking control words on data lines, chosen by disparity sign.
  localparam logic [6:0] CW_C0_POS = 7'h70;
  localparam logic [6:0] CW_C0_NEG = 7'h78;
  localparam logic [6:0] CW_C1_POS = 7'h60;
  localparam logic [6:0] CW_C1_NEG = 7'h7C;

  // Clock line words: active and blanking pairs, plus the plain clock.
  localparam logic [6:0] CK_ACT_NEG = 7'h78;
  localparam logic [6:0] CK_ACT_POS = 7'h70;
  localparam logic [6:0] CK_BLK_NEG = 7'h7C;
  localparam logic [6:0] CK_BLK_POS = 7'h60;
  localparam logic [6:0] CK_PLAIN = 7'h63;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DISP = 8'h08;

  // Control register fields and value after reset.
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_CLR_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b1;

  // Status register field positions.
  localparam int unsigned STAT_STRAP_POS = 0;
  localparam int unsigned STAT_ACTIVE_POS = 4;
  localparam int unsigned STAT_CLKRD_POS = 8;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Strapped configuration pins, kept together.
  typedef struct packed {
    logic edge_select;
    logic enable_polarity_select;
    logic balance_select;
    logic dual_select;
  } dlc_strap_t;

endpackage
`default_nettype wire

// *** hdl/dlc_encoder.sv ***
// Purpose: DC-balance line encoder for a serial display link transmitter.
// Assumes: Pixel clock and pins are asynchronous to aclk and much slower.
// Notes: One set of seven-bit words per lane is produced per primary edge.
// Operation
// - Data disparity equals ones minus zeros.
// - Running disparity saturates at +7 and -6.
// - Accumulate d-1 unaltered, 1-d inverted.
// - Invert per running and data disparity signs.
// - Balance bit zero unaltered, one inverted.
// - Balanced mode adds balance bit per line.
// - Balanced mode carries enable on clock lines.
// - Clock line patterns for active and blanking.
// - Control zero word depends on disparity sign.
// - Control one word depends on disparity sign.
// - Sync control is never inverted.
// - Balance bit zero during blanking control.
// - Unbalanced mode sends plain bits unaltered.
// - Dual mode drives both link clocks identically.
// - Edge select picks primary input clock edge.
// - Polarity select picks active enable level.
// - Balance select enables or disables balancing.
// - Dual select picks two or one pixel.
// - Low polarity swaps active and blanking handling on data and clock lines.
`timescale 1ns/10ps
`default_nettype none
module dlc_encoder #(
  parameter int unsigned LANES = 4,
  parameter int unsigned ADDR_W = 8
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pixel side pins from the host.
  input wire logic pix_clk,
  input wire logic pixel_valid,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic [2*LANES*dlc_pkg::WORD_W-1:0] pix_data,
  input wire dlc_pkg::dlc_strap_t straps,
  // Encoded link words.
  output logic [2*LANES*dlc_pkg::WORD_W-1:0] link_data,
  output logic [2*LANES-1:0] balance_bit,
  output logic [dlc_pkg::WORD_W-1:0] link_clock_a,
  output logic [dlc_pkg::WORD_W-1:0] link_clock_b,
  output logic word_strobe
);
  import dlc_pkg::*;

  // Refuse lane counts that the disparity register cannot show.
  if (LANES < 2 || LANES > 4)
  begin : g_check
    $error("dlc_encoder: LANES must lie between 2 and 4");
  end

  localparam int unsigned NL = 2 * LANES;
  localparam int unsigned PIX_W = NL * WORD_W;
  localparam int unsigned SYNC_W = PIX_W + 8;

  // Count of set bits in a seven-bit word.
  function automatic logic [2:0] ones7(input logic [6:0] w);
    logic [2:0] n;
    n = 3'h0;
    for (int b = 0; b < 7; b++)
    begin
      n = n + {2'h0, w[b]};
    end
    return n;
  endfunction

  // Disparity of a six-bit word: ones minus zeros.
  function automatic logic signed [4:0] disp6(input logic [5:0] d);
    logic [2:0] n;
    n = ones7({1'b0, d});
    return $signed({1'b0, n, 1'b0}) - 5'sh06;
  endfunction

  // Disparity of a seven-bit word.
  function automatic logic signed [4:0] disp7(input logic [6:0] w);
    logic [2:0] n;
    n = ones7(w);
    return $signed({1'b0, n, 1'b0}) - 5'sh07;
  endfunction

  // Add a delta to the running disparity with saturation.
  function automatic logic signed [3:0] sat_add(input logic signed [3:0] rd, input logic signed [4:0] dl);
    logic signed [5:0] s;
    s = $signed({{2{rd[3]}}, rd}) + $signed({dl[4], dl});
    if (s > RD_MAX)
    begin
      s = RD_MAX;
    end
    else if (s < RD_MIN)
    begin
      s = RD_MIN;
    end
    return s[3:0];
  endfunction

  // Two-flop synchronisers for every pin; the first stage feeds only the second.
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_s1_r;
  logic [SYNC_W-1:0] pin_s2_r;
  logic clk_s3_r;
  assign pin_raw = {straps, pix_clk, pixel_valid, hsync, vsync, pix_data};

  // Synchroniser chain and the extra clock stage for edge finding.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      clk_s3_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      clk_s3_r <= pin_s2_r[PIX_W+3];
    end
  end

  // Synchronised views of the pins.
  dlc_strap_t strap_s;
  logic clk_s;
  logic valid_s;
  logic hsync_s;
  logic vsync_s;
  logic [PIX_W-1:0] data_s;
  assign strap_s = dlc_strap_t'(pin_s2_r[SYNC_W-1 -: 4]);
  assign clk_s = pin_s2_r[PIX_W+3];
  assign valid_s = pin_s2_r[PIX_W+2];
  assign hsync_s = pin_s2_r[PIX_W+1];
  assign vsync_s = pin_s2_r[PIX_W];
  assign data_s = pin_s2_r[PIX_W-1:0];

  // Software control state.
  logic link_en_r;
  logic rd_clear_r;
  logic primary_edge;
  logic pix_active;
  logic capture;

  // edge select
  // A falling strap makes the high-to-low transition the capture point.
  assign primary_edge = strap_s.edge_select ? (clk_s3_r & ~clk_s) : (~clk_s3_r & clk_s);

  // enable polarity
  // Active display is the pixel valid level that matches the strap.
  assign pix_active = (valid_s == strap_s.enable_polarity_select);
  assign capture = primary_edge & link_en_r;

  // Per-lane running disparity and next words.
  logic signed [3:0] rd_r [NL];
  logic signed [3:0] rd_nxt [NL];
  logic [WORD_W-1:0] word_nxt [NL];
  logic balance_nxt [NL];

  for (genvar i = 0; i < NL; i++)
  begin : g_lane
    logic [DATA_W-1:0] pd;
    logic [WORD_W-1:0] plain;
    logic signed [4:0] d;
    logic inv;
    logic ctl;
    logic [WORD_W-1:0] cw;
    logic lane_on;
    assign pd = data_s[i*WORD_W +: DATA_W];
    assign plain = data_s[i*WORD_W +: WORD_W];
    assign d = disp6(pd);
    // Line zero carries horizontal sync, line one vertical; others send zero.
    assign ctl = (i == 0) ? hsync_s : ((i == 1) ? vsync_s : 1'b0);
    // pixel width
    // Upper lanes only run when the dual strap is high.
    assign lane_on = (i < LANES) || strap_s.dual_select;

    // Word selection for this lane.
    always_comb
    begin
      if (rd_r[i] > 4'sh0)
      begin
        inv = (d > 5'sh00);
      end
      else if (rd_r[i] < 4'sh0)
      begin
        inv = (d <= 5'sh00);
      end
      else
      begin
        inv = 1'b1;
      end
      if (rd_r[i] > 4'sh0)
      begin
        cw = ctl ? CW_C1_POS : CW_C0_POS;
      end
      else
      begin
        cw = ctl ? CW_C1_NEG : CW_C0_NEG;
      end
      rd_nxt[i] = rd_r[i];
      if (!lane_on)
      begin
        // A disabled lane stays quiet and keeps its disparity.
        word_nxt[i] = '0;
        balance_nxt[i] = 1'b0;
      end
      else if (!strap_s.balance_select)
      begin
        word_nxt[i] = plain;
        balance_nxt[i] = 1'b0;
      end
      else if (pix_active)
      begin
        word_nxt[i] = {inv, inv ? ~pd : pd};
        balance_nxt[i] = inv;
        rd_nxt[i] = sat_add(rd_r[i], inv ? (5'sh01 - d) : (d - 5'sh01));
      end
      else
      begin
        // host valid
        // The blanking decision relies on the host keeping pixel valid live.
        word_nxt[i] = cw;
        balance_nxt[i] = 1'b0;
        // Control words still move the line's balance.
        rd_nxt[i] = sat_add(rd_r[i], disp7(cw));
      end
    end
  end

  // Clock line tracker: the two patterns per state have opposite disparity.
  logic signed [3:0] ck_rd_r;
  logic signed [3:0] ck_rd_nxt;
  logic [WORD_W-1:0] ck_word_nxt;

  // Clock word selection.
  always_comb
  begin
    ck_rd_nxt = ck_rd_r;
    if (!strap_s.balance_select)
    begin
      // Plain clock shape when balancing is off.
      ck_word_nxt = CK_PLAIN;
    end
    else
    begin
      // polarity swap
      // Active-ness, not the raw pin level, picks the pattern pair.
      if (pix_active)
      begin
        ck_word_nxt = (ck_rd_r > 4'sh0) ? CK_ACT_POS : CK_ACT_NEG;
      end
      else
      begin
        ck_word_nxt = (ck_rd_r > 4'sh0) ? CK_BLK_POS : CK_BLK_NEG;
      end
      ck_rd_nxt = sat_add(ck_rd_r, disp7(ck_word_nxt));
    end
  end

  // Output words and running disparities, updated on each captured edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < NL; i++)
      begin
        rd_r[i] <= RD_RESET;
      end
      ck_rd_r <= RD_RESET;
      link_data <= '0;
      balance_bit <= '0;
      link_clock_a <= '0;
      link_clock_b <= '0;
      word_strobe <= 1'b0;
    end
    else
    begin
      word_strobe <= capture;
      if (rd_clear_r)
      begin
        // Software restart of the balance trackers takes priority.
        for (int i = 0; i < NL; i++)
        begin
          rd_r[i] <= RD_RESET;
        end
        ck_rd_r <= RD_RESET;
      end
      else if (capture)
      begin
        for (int i = 0; i < NL; i++)
        begin
          rd_r[i] <= rd_nxt[i];
        end
        ck_rd_r <= ck_rd_nxt;
      end
      if (capture)
      begin
        for (int i = 0; i < NL; i++)
        begin
          link_data[i*WORD_W +: WORD_W] <= word_nxt[i];
          balance_bit[i] <= balance_nxt[i];
        end
        link_clock_a <= ck_word_nxt;
        // identical clocks
        // The second clock is idle unless two pixels travel per clock.
        link_clock_b <= strap_s.dual_select ? ck_word_nxt : '0;
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order.
  logic aw_have_r;
  logic w_have_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  assign wr_fire = aw_have_r & w_have_r & ~s_axi_bvalid;

  // Write channel handshakes and response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only the control word accepts writes; others are refused.
        s_axi_bresp <= (awaddr_r == ADDR_W'(ADDR_CTRL)) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        // Readiness returns only after the response, so one write at a time.
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control register: enable bit and self-clearing disparity restart.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_en_r <= CTRL_EN_RESET;
      rd_clear_r <= 1'b0;
    end
    else
    begin
      rd_clear_r <= 1'b0;
      if (wr_fire && awaddr_r == ADDR_W'(ADDR_CTRL) && wstrb_r[0])
      begin
        link_en_r <= wdata_r[CTRL_EN_BIT];
        rd_clear_r <= wdata_r[CTRL_CLR_BIT];
      end
    end
  end

  // Read data multiplexer.
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb
  begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr == ADDR_W'(ADDR_CTRL))
    begin
      rd_word[CTRL_EN_BIT] = link_en_r;
    end
    else if (s_axi_araddr == ADDR_W'(ADDR_STATUS))
    begin
      rd_word[STAT_STRAP_POS +: 4] = strap_s;
      rd_word[STAT_ACTIVE_POS] = pix_active;
      rd_word[STAT_CLKRD_POS +: 4] = ck_rd_r;
    end
    else if (s_axi_araddr == ADDR_W'(ADDR_DISP))
    begin
      // Four bits of signed disparity per lane, lane zero lowest.
      for (int i = 0; i < NL; i++)
      begin
        rd_word[i*4 +: 4] = rd_r[i];
      end
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  // Read channel: answer one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** sim/dlc_encoder_props.sv ***
// Purpose: Port-level checks of the link encoder and its register bus.
// Assumes: Balanced clock words mark active or blanking cycles.
// Notes: Bound into the encoder by the statement after the module.
`timescale 1ns/10ps
`default_nettype none
module dlc_encoder_props #(
  parameter int unsigned LANES = 4,
  parameter int unsigned ADDR_W = 8
)
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Link words.
  input wire logic [2*LANES*dlc_pkg::WORD_W-1:0] link_data,
  input wire logic [2*LANES-1:0] balance_bit,
  input wire logic [dlc_pkg::WORD_W-1:0] link_clock_a,
  input wire logic [dlc_pkg::WORD_W-1:0] link_clock_b,
  input wire logic word_strobe
);
  import dlc_pkg::*;

  // All checks share the bus clock and its reset.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  strobe_pulse_a: assert property (word_strobe |=> !word_strobe)
    else $error("word strobe lasted more than one cycle");
  hold_words_a: assert property (!word_strobe |-> $stable(link_data) && $stable(link_clock_a))
    else $error("link words changed without a strobe");
  clock_word_a: assert property (word_strobe |-> link_clock_a inside {7'h78, 7'h70, 7'h7C, 7'h60, 7'h63})
    else $error("clock line word outside the allowed set");
  dual_clock_a: assert property (word_strobe |-> link_clock_b == link_clock_a || link_clock_b == 7'h00)
    else $error("second clock line differs from the first");
  blank_ctl_a: assert property (word_strobe && link_clock_a inside {7'h7C, 7'h60}
    |-> link_data[6:0] inside {7'h70, 7'h78, 7'h60, 7'h7C} && link_data[13:7] inside {7'h70, 7'h78, 7'h60, 7'h7C})
    else $error("sync lanes carry no control word in blanking");
  blank_balance_a: assert property (word_strobe && link_clock_a inside {7'h7C, 7'h60} |-> balance_bit == '0)
    else $error("balance bit set during blanking");
  active_balance_a: assert property (word_strobe && link_clock_a inside {7'h78, 7'h70}
    |-> balance_bit[0] == link_data[6] && balance_bit[3] == link_data[27])
    else $error("balance bit differs from word bit six");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule

bind dlc_encoder dlc_encoder_props #(.LANES(LANES), .ADDR_W(ADDR_W)) u_dlc_encoder_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .link_data,
  .balance_bit, .link_clock_a, .link_clock_b, .word_strobe);
`default_nettype wire

// *** sim/dlc_link_rx.sv ***
// Purpose: Panel-side receiver that recovers the lane zero pixel.
// Assumes: Words are read in the cycle the encoder strobes them.
// Notes: Blanking words leave the last recovered pixel in place.
`timescale 1ns/10ps
`default_nettype none
module dlc_link_rx (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Words from the encoder.
  input wire logic [6:0] lane_word,
  input wire logic [6:0] clock_word,
  input wire logic word_strobe,
  // Recovered pixel.
  output logic [5:0] rx_pixel
);
  // undo inversion
  // Only active clock words carry pixels, so control words are never decoded.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx_pixel <= 6'h00;
    else if (word_strobe && (clock_word == 7'h70 || clock_word == 7'h78))
      rx_pixel <= lane_word[6] ? ~lane_word[5:0] : lane_word[5:0];
  end
endmodule
`default_nettype wire

// *** sim/dlc_encoder_test.sv ***
// Purpose: Self-checking bench for the link encoder.
// Assumes: Pixel clock of 200 ns made here, eight bus cycles a period.
// Notes: Expected words come from a lane-by-lane disparity model.
`timescale 1ns/10ps
`default_nettype none
module dlc_encoder_test;
  import dlc_pkg::*;
  logic aclk, aresetn, pix_clk, pixel_valid, hsync, vsync, word_strobe;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, balance_bit, exp_balance;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [55:0] pix_data, link_data, exp_data;
  logic [6:0] link_clock_a, link_clock_b, exp_clk;
  logic [5:0] rx_pixel;
  dlc_strap_t straps;
  // Model disparities of eight lanes and of the clock line.
  int rd[8];
  int crd;
  int bad_count, samples_checked;
  logic [5:0] tab[8] = '{6'h3F, 6'h00, 6'h07, 6'h38, 6'h15, 6'h2A, 6'h01, 6'h3E};

  dlc_encoder u_dlc_encoder (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pix_clk,
    .pixel_valid, .hsync, .vsync, .pix_data, .straps, .link_data, .balance_bit, .link_clock_a,
    .link_clock_b, .word_strobe);
  dlc_link_rx u_dlc_link_rx (.aclk, .aresetn, .lane_word(link_data[6:0]), .clock_word(link_clock_a),
    .word_strobe, .rx_pixel);

  // Bus clock at 40 MHz.
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Saturating sum, so the model never leaves the permitted range.
  function automatic int sat(input int v);
    return (v > 7) ? 7 : ((v < -6) ? -6 : v);
  endfunction

  // One active word: invert by signs, then add the modified disparity.
  function automatic logic [6:0] enc(inout int r, input logic [5:0] x);
    int d;
    logic inv;
    d = 2 * $countones(x) - 6;
    inv = (r > 0) ? (d > 0) : ((r < 0) ? (d <= 0) : 1'b1);
    r = sat(r + (inv ? 1 - d : d - 1));
    return {inv, inv ? ~x : x};
  endfunction

  // One control word picked by disparity sign; it moves disparity by its own weight.
  function automatic logic [6:0] cw(inout int r, input logic one);
    logic [6:0] w;
    w = one ? ((r > 0) ? 7'h60 : 7'h7C) : ((r > 0) ? 7'h70 : 7'h78);
    r = sat(r + 2 * $countones(w) - 7);
    return w;
  endfunction

  function automatic logic [31:0] disp();
    logic [31:0] v;
    for (int i = 0; i < 8; i++)
      v[4*i +: 4] = rd[i][3:0];
    return v;
  endfunction

  // Write and read hold each request until taken; ready follows the answer by a cycle.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid)
        break;
      if (s_axi_bvalid)
        s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (n == 40)
    begin
      check(0, 1);
      summarize();
    end
    else
      check(s_axi_bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid)
        break;
      if (s_axi_rvalid)
        s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    if (n == 40)
    begin
      check(0, 1);
      summarize();
    end
    else
    begin
      check(s_axi_rdata, ed);
      check(s_axi_rresp, er);
    end
  endtask

  // One pixel period: primary edge after one cycle, the other edge four later.
  task automatic pix(input int k, input logic pv, input logic hs, input logic vs, input logic cap);
    int s;
    logic act;
    logic [6:0] w;
    s = 0;
    act = (pv == straps.enable_polarity_select);
    for (int i = 0; i < 8; i++)
      pix_data[7*i +: 7] <= {i[0], tab[(k + i) % 8]};
    pixel_valid <= pv;
    hsync <= hs;
    vsync <= vs;
    for (int n = 0; n < 8; n++)
    begin
      @(posedge aclk);
      if (n == 1)
        pix_clk <= !straps.edge_select;
      if (n == 5)
        pix_clk <= straps.edge_select;
      if (word_strobe === 1'b1)
        s++;
    end
    if (cap)
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (i >= 4 && !straps.dual_select)
          w = 7'h00;
        else if (!straps.balance_select)
          w = {i[0], tab[(k + i) % 8]};
        else if (act)
          w = enc(rd[i], tab[(k + i) % 8]);
        else
          w = cw(rd[i], (i == 0) ? hs : ((i == 1) && vs));
        exp_data[7*i +: 7] = w;
        exp_balance[i] = straps.balance_select && act && w[6];
      end
      exp_clk = straps.balance_select ? cw(crd, !act) : 7'h63;
    end
    check(s, cap);
    check(link_data, exp_data);
    check(balance_bit, exp_balance);
    check(link_clock_a, exp_clk);
    check(link_clock_b, straps.dual_select ? exp_clk : 7'h00);
    if (cap && act && straps.balance_select)
      check(rx_pixel, tab[k % 8]);
  endtask

  initial
  begin
    {aresetn, pix_clk, pixel_valid, hsync, vsync, pix_data} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    straps = '{1'b0, 1'b1, 1'b1, 1'b1};
    {bad_count, samples_checked, crd} = '0;
    rd = '{default: 0};
    {exp_data, exp_balance, exp_clk} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_rd(8'h08, 32'h0, 2'h0);
    axi_rd(8'h0C, 32'h0, 2'h2);
    axi_wr(8'h04, 32'h0, 2'h2);
    axi_rd(8'h00, 32'h1, 2'h0);
    for (int k = 0; k < 12; k++)
      pix(k, 1'b1, 1'b0, 1'b0, 1'b1);
    for (int k = 0; k < 4; k++)
      pix(k, 1'b0, k[0], k[1], 1'b1);
    axi_rd(8'h08, disp(), 2'h0);
    // Low polarity: a low enable now marks active data.
    straps.enable_polarity_select <= 1'b0;
    repeat (4) @(posedge aclk);
    pix(0, 1'b0, 1'b0, 1'b0, 1'b1);
    pix(1, 1'b1, 1'b1, 1'b1, 1'b1);
    straps.dual_select <= 1'b0;
    repeat (4) @(posedge aclk);
    pix(2, 1'b0, 1'b0, 1'b0, 1'b1);
    pix(3, 1'b1, 1'b1, 1'b0, 1'b1);
    // Capture disabled: outputs must hold with no strobe.
    axi_wr(8'h00, 32'h0, 2'h0);
    pix(4, 1'b0, 1'b0, 1'b0, 1'b0);
    axi_wr(8'h00, 32'h3, 2'h0);
    rd = '{default: 0};
    crd = 0;
    axi_rd(8'h08, 32'h0, 2'h0);
    straps <= '{1'b0, 1'b0, 1'b0, 1'b1};
    repeat (4) @(posedge aclk);
    pix(5, 1'b0, 1'b0, 1'b0, 1'b1);
    pix(6, 1'b1, 1'b1, 1'b1, 1'b1);
    axi_rd(8'h08, disp(), 2'h0);
    // Falling edge primary; the pin is parked high first, which must not capture.
    straps <= '{1'b1, 1'b0, 1'b1, 1'b1};
    repeat (4) @(posedge aclk);
    pix_clk <= 1'b1;
    repeat (4) @(posedge aclk);
    pix(7, 1'b0, 1'b0, 1'b0, 1'b1);
    pix(0, 1'b1, 1'b0, 1'b1, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
